//--- logic/drp_profile_top.sv
`timescale 1ns/1ps
module drp_profile_top (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [13:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ref_a_selected,
    output logic ref_a_enabled,
    output logic [1:0] ref_a_priority,
    output logic loop_profile_valid,
    output logic [16:0] loop_bw_factor,
    output logic loop_filter_high_margin,
    output logic [18:0] loop_int_ratio,
    output logic [23:0] loop_frac_numerator,
    output logic [23:0] loop_frac_modulus,
    output logic loop_frac_enable
);
    // ****************************************
    // Register bank
    // ****************************************
    drp_profile_if prof ();
    logic [18:0] int_ratio;
    logic frac_on;
    logic [7:0] status_byte;

    typedef struct packed {
        logic valid;
        logic [16:0] bw;
        logic filt;
        logic [18:0] ratio;
        logic [23:0] num;
        logic [23:0] modv;
        logic frac;
    } drp_out_state_t;

    drp_out_state_t st;
    drp_out_state_t next_st;
    logic active;

    always_comb begin
        status_byte = 8'h0;
        status_byte[drp_pkg::POS_STAT_ACTIVE] = st.valid;
        status_byte[drp_pkg::POS_STAT_FRAC_ON] = frac_on;
        status_byte[drp_pkg::POS_STAT_FILTER] = prof.filter_sel;
    end

    drp_apb_regs u_regs (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .pstrb(pstrb),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .status_byte(status_byte),
        .prof(prof)
    );

    drp_divider u_div (
        .int_minus_one(prof.int_minus_one),
        .modulus(prof.modulus),
        .int_ratio(int_ratio),
        .frac_on(frac_on)
    );

    // ****************************************
    // Profile delivery to loop zero
    // ****************************************
    assign active = ref_a_selected && prof.ref_enable;

    always_comb begin
        next_st = st;
        next_st.valid = active;
        if (active) begin
            next_st.bw = prof.bw_factor;
            next_st.filt = prof.filter_sel == drp_pkg::DRP_FILTER_HIGH_MARGIN;
            next_st.ratio = int_ratio;
            next_st.frac = frac_on;
            next_st.num = frac_on ? prof.numerator : 24'h0;
            next_st.modv = frac_on ? prof.modulus : 24'h0;
        end
        if (!reset_n) begin
            next_st = '0;
        end
    end

    always_ff @(posedge clk_sys) begin
        st <= next_st;
    end

    assign ref_a_enabled = prof.ref_enable;
    assign ref_a_priority = prof.priority_code;
    assign loop_profile_valid = st.valid;
    assign loop_bw_factor = st.bw;
    assign loop_filter_high_margin = st.filt;
    assign loop_int_ratio = st.ratio;
    assign loop_frac_numerator = st.num;
    assign loop_frac_modulus = st.modv;
    assign loop_frac_enable = st.frac;
endmodule : drp_profile_top

//--- pkg/drp_pkg.sv
package drp_pkg;
    // ****************************************
    // Register indices (byte registers, byte address = 4 * index)
    // ****************************************
    localparam logic [11:0] IDX_REF_CONTROL = 12'h440;
    localparam logic [11:0] IDX_BW_LOW = 12'h441;
    localparam logic [11:0] IDX_BW_MID = 12'h442;
    localparam logic [11:0] IDX_FILTER_BW_TOP = 12'h443;
    localparam logic [11:0] IDX_INT_LOW = 12'h444;
    localparam logic [11:0] IDX_INT_MID = 12'h445;
    localparam logic [11:0] IDX_INT_TOP = 12'h446;
    localparam logic [11:0] IDX_NUM_LOW = 12'h447;
    localparam logic [11:0] IDX_NUM_MID = 12'h448;
    localparam logic [11:0] IDX_NUM_HIGH = 12'h449;
    localparam logic [11:0] IDX_MOD_LOW = 12'h44a;
    localparam logic [11:0] IDX_MOD_MID = 12'h44b;
    localparam logic [11:0] IDX_MOD_HIGH = 12'h44c;
    localparam logic [11:0] IDX_STATUS = 12'h44d;
    localparam int NUM_REGS = 14;

    // ****************************************
    // Field positions and reset values
    // ****************************************
    localparam int POS_ENABLE = 0;
    localparam int POS_PRIO_LSB = 1;
    localparam int POS_BW_BIT16 = 0;
    localparam int POS_FILTER_SEL = 1;
    localparam int POS_STAT_ACTIVE = 0;
    localparam int POS_STAT_FRAC_ON = 1;
    localparam int POS_STAT_FILTER = 2;
    localparam logic [7:0] MASK_REF_CONTROL = 8'h07;
    localparam logic [7:0] MASK_FILTER_BW_TOP = 8'h03;
    localparam logic [7:0] MASK_INT_TOP = 8'h03;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam int BW_UNIT_CENTI_HZ = 10;

    typedef enum logic [0:0] {
        DRP_FILTER_NORMAL = 1'b0,
        DRP_FILTER_HIGH_MARGIN = 1'b1
    } drp_filter_t;
endpackage : drp_pkg

//--- pkg/drp_profile_if.sv
`timescale 1ns/1ps
interface drp_profile_if;
    logic [16:0] bw_factor;
    drp_pkg::drp_filter_t filter_sel;
    logic [17:0] int_minus_one;
    logic [23:0] numerator;
    logic [23:0] modulus;
    logic [1:0] priority_code;
    logic ref_enable;

    modport source (
        output bw_factor, filter_sel, int_minus_one, numerator, modulus,
        output priority_code, ref_enable
    );
    modport sink (
        input bw_factor, filter_sel, int_minus_one, numerator, modulus,
        input priority_code, ref_enable
    );
endinterface : drp_profile_if

//--- logic/drp_apb_regs.sv
`timescale 1ns/1ps
module drp_apb_regs (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [13:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] status_byte,
    drp_profile_if.source prof
);
    typedef struct packed {
        logic [drp_pkg::NUM_REGS-1:0][7:0] regs;
        logic [31:0] rdata;
    } drp_regs_state_t;

    drp_regs_state_t st;
    drp_regs_state_t next_st;
    logic [11:0] idx;
    logic hit;
    logic [3:0] slot;
    logic [7:0] rd_byte;

    assign idx = paddr[13:2];
    assign hit = (idx >= drp_pkg::IDX_REF_CONTROL) && (idx <= drp_pkg::IDX_STATUS);
    assign slot = 4'(idx - drp_pkg::IDX_REF_CONTROL);

    always_comb begin
        rd_byte = st.regs[slot];
        if (idx == drp_pkg::IDX_STATUS) begin
            rd_byte = status_byte;
        end
    end

    always_comb begin
        next_st = st;
        // Read byte caught in setup so it stands from a flop in access
        next_st.rdata = 32'h0;
        if (psel && !penable && hit && !pwrite) begin
            next_st.rdata = {24'h0, rd_byte};
        end
        if (psel && penable) begin
            if (hit && pwrite && pstrb[0] && idx != drp_pkg::IDX_STATUS) begin
                next_st.regs[slot] = pwdata[7:0];
                // Reserved bits hold zero
                unique case (idx)
                    drp_pkg::IDX_REF_CONTROL:
                        next_st.regs[slot] = pwdata[7:0] & drp_pkg::MASK_REF_CONTROL;
                    drp_pkg::IDX_FILTER_BW_TOP:
                        next_st.regs[slot] = pwdata[7:0] & drp_pkg::MASK_FILTER_BW_TOP;
                    drp_pkg::IDX_INT_TOP:
                        next_st.regs[slot] = pwdata[7:0] & drp_pkg::MASK_INT_TOP;
                    default: ;
                endcase
            end
        end
        if (!reset_n) begin
            next_st.regs = '0;
            next_st.rdata = 32'h0;
        end
    end

    always_ff @(posedge clk_sys) begin
        st <= next_st;
    end

    assign pready = 1'b1;
    assign prdata = st.rdata;
    always_comb begin
        pslverr = 1'b0;
        if (psel && penable) begin
            pslverr = !hit;
        end
    end

    // ****************************************
    // Field decode
    // ****************************************
    assign prof.bw_factor = {st.regs[3][drp_pkg::POS_BW_BIT16], st.regs[2], st.regs[1]};
    assign prof.filter_sel = drp_pkg::drp_filter_t'(st.regs[3][drp_pkg::POS_FILTER_SEL]);
    assign prof.int_minus_one = {st.regs[6][1:0], st.regs[5], st.regs[4]};
    assign prof.numerator = {st.regs[9], st.regs[8], st.regs[7]};
    assign prof.modulus = {st.regs[12], st.regs[11], st.regs[10]};
    assign prof.priority_code = st.regs[0][drp_pkg::POS_PRIO_LSB +: 2];
    assign prof.ref_enable = st.regs[0][drp_pkg::POS_ENABLE];
endmodule : drp_apb_regs

//--- logic/drp_divider.sv
`timescale 1ns/1ps
module drp_divider (
    input wire logic [17:0] int_minus_one,
    input wire logic [23:0] modulus,
    output logic [18:0] int_ratio,
    output logic frac_on
);
    assign int_ratio = 19'(int_minus_one) + 19'h1;
    assign frac_on = modulus != 24'h0;
endmodule : drp_divider

//--- bench/drp_profile_properties.sv
`timescale 1ns/1ps
module drp_profile_properties (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic [13:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic ref_a_selected,
    input wire logic ref_a_enabled,
    input wire logic loop_profile_valid,
    input wire logic [16:0] loop_bw_factor,
    input wire logic [18:0] loop_int_ratio,
    input wire logic [23:0] loop_frac_numerator,
    input wire logic [23:0] loop_frac_modulus,
    input wire logic loop_frac_enable
);
    // ****
    // Properties
    // ****
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    zero_wait_a:
    assert property (psel && penable |-> pready) else $error("wait state seen");
    idle_bus_a:
    assert property (!(psel && penable) |-> prdata == 0) else $error("idle read data");
    err_decode_a:
    assert property (psel && penable && paddr[1:0] == 0 |-> pslverr ==
        (paddr[13:2] < 12'h440 || paddr[13:2] > 12'h44d)) else $error("bad decode");
    reset_clear_a:
    assert property ($rose(reset_n) |-> loop_bw_factor == 0 && !loop_profile_valid)
        else $error("not clear after reset");
    valid_track_a:
    assert property (loop_profile_valid == $past(ref_a_selected && ref_a_enabled && reset_n))
        else $error("valid wrong");
    profile_frozen_a:
    assert property (!ref_a_selected |=> $stable(loop_bw_factor) &&
        $stable(loop_int_ratio)) else $error("profile moved");
    ratio_nonzero_a:
    assert property (ref_a_selected && ref_a_enabled |=> loop_int_ratio != 0)
        else $error("ratio zero");
    frac_bypass_a:
    assert property (loop_frac_enable == (loop_frac_modulus != 0)) else $error("bypass");
    num_cleared_a:
    assert property (!loop_frac_enable |-> loop_frac_numerator == 24'h0)
        else $error("numerator kept in bypass");
endmodule : drp_profile_properties
bind drp_profile_top drp_profile_properties chk (.clk_sys, .reset_n, .psel, .penable,
    .paddr, .prdata, .pready, .pslverr, .ref_a_selected, .ref_a_enabled,
    .loop_profile_valid, .loop_bw_factor, .loop_int_ratio, .loop_frac_numerator,
    .loop_frac_modulus, .loop_frac_enable);

//--- bench/tb_dpll_reference_profile_settings.sv
`timescale 1ns/1ps
module tb_dpll_reference_profile_settings;
    logic clk_sys = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [13:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata;
    logic [3:0] pstrb = 0;
    logic pready, pslverr, ref_a_selected = 0, ref_a_enabled, loop_profile_valid;
    logic loop_filter_high_margin, loop_frac_enable;
    logic [1:0] ref_a_priority;
    logic [16:0] loop_bw_factor;
    logic [18:0] loop_int_ratio;
    logic [23:0] loop_frac_numerator, loop_frac_modulus;
    logic [32:0] expq[$];
    logic [7:0] rv[12];
    int num_errors = 0, checks_done = 0;
    integer seed = 32'h53877615;
    always #10 clk_sys = ~clk_sys;
    drp_profile_top dut (.clk_sys, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb, .prdata, .pready, .pslverr, .ref_a_selected, .ref_a_enabled,
        .ref_a_priority, .loop_profile_valid, .loop_bw_factor, .loop_filter_high_margin,
        .loop_int_ratio, .loop_frac_numerator, .loop_frac_modulus, .loop_frac_enable);
    // ****
    // Tasks
    // ****
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] s);
        checks_done++;
        if (e !== s) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] i, input logic [7:0] d,
        input logic [32:0] e);
        @(posedge clk_sys);
        psel <= 1;
        pwrite <= w;
        paddr <= {i, 2'b00};
        pwdata <= {24'($random(seed)), d};
        pstrb <= 4'hf;
        if (!w) expq.push_back(e);
        @(posedge clk_sys);
        penable <= 1;
        do @(posedge clk_sys); while (!pready);
        psel <= 0;
        penable <= 0;
    endtask : apb
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish
    // Read results are matched against the oldest note
    always @(posedge clk_sys) begin
        if (psel && penable && pready && !pwrite) chk("read", expq.pop_front(), {pslverr, prdata});
    end
    // ****
    // Tests
    // ****
    initial begin
        repeat (6) @(posedge clk_sys);
        reset_n <= 1;
        for (int i = 0; i < 13; i++) apb(0, 12'h440 + i, 0, 0);
        $display("test reset done");
        for (int i = 0; i < 12; i++) begin
            rv[i] = 8'($random(seed));
            // Factor kept at 51.2 Hz or more; phase detector taken far above 50x the top
            if (i == 1) rv[i][1] = 1'b1;
            apb(1, 12'h441 + i, rv[i], 0);
        end
        rv[2] &= drp_pkg::MASK_FILTER_BW_TOP;
        rv[5] &= drp_pkg::MASK_INT_TOP;
        for (int i = 0; i < 12; i++) apb(0, 12'h441 + i, 0, {25'h0, rv[i]});
        apb(0, 12'h450, 0, 33'h100000000);
        $display("test readback done");
        apb(1, 12'h440, 8'h05, 0);
        ref_a_selected <= 1;
        repeat (3) @(posedge clk_sys);
        chk("bw", {rv[2][0], rv[1], rv[0]}, loop_bw_factor);
        chk("filter", rv[2][1], loop_filter_high_margin);
        chk("ratio", {rv[5][1:0], rv[4], rv[3]} + 1, loop_int_ratio);
        chk("num", {rv[8], rv[7], rv[6]}, loop_frac_numerator);
        chk("mod", {rv[11], rv[10], rv[9]}, loop_frac_modulus);
        chk("frac", |{rv[11], rv[10], rv[9]}, loop_frac_enable);
        chk("valid", 1, loop_profile_valid);
        chk("enabled", 1, ref_a_enabled);
        for (int i = 3; i < 12; i++) if (i < 6 || i > 8) apb(1, 12'h441 + i, 0, 0);
        repeat (3) @(posedge clk_sys);
        chk("ratio one", 1, loop_int_ratio);
        chk("bypass", 0, loop_frac_enable);
        chk("num off", 0, loop_frac_numerator);
        apb(1, 12'h44d, 8'hff, 0);
        apb(0, 12'h44d, 0, {30'h0, rv[2][1], 2'b01});
        for (int k = 0; k < 4; k++) begin
            apb(1, 12'h440, 8'(k * 2 + 1), 0);
            apb(1, 12'h443, 8'(k * 2 & 2), 0);
            repeat (3) @(posedge clk_sys);
            chk("prio", k, ref_a_priority);
            chk("margin", k & 1, loop_filter_high_margin);
        end
        $display("test profile done");
        ref_a_selected <= 0;
        apb(1, 12'h441, ~rv[0], 0);
        apb(1, 12'h440, 0, 0);
        repeat (3) @(posedge clk_sys);
        chk("frozen", rv[0], loop_bw_factor[7:0]);
        ref_a_selected <= 1;
        repeat (3) @(posedge clk_sys);
        chk("disabled", 0, loop_profile_valid);
        chk("enabled off", 0, ref_a_enabled);
        $display("test freeze done");
        reset_n <= 0;
        repeat (2) @(posedge clk_sys);
        reset_n <= 1;
        apb(0, 12'h441, 0, 0);
        chk("bw after reset", 0, loop_bw_factor);
        $display("test second reset done");
        tally_and_finish();
    end
    initial begin
        repeat (2000) @(posedge clk_sys);
        num_errors++;
        tally_and_finish();
    end
endmodule : tb_dpll_reference_profile_settings
